// *** design/vpss_sequencer.sv ***
`timescale 1ns/1ps
`include "vpss_defs.svh"

// Summary of operation
// - a no-op starts in class 3 step 2
// - no-op waits without transfers while buffer busy and no interrupt cycle
// - pipe advance: pc to buffer address, pc+1, expand saved or buffer word
// - pipe advance clears the saved-next flag
// - pipe advance reads the word at buffer address; controller returns it
// - class 010/1 indirect, 011/1 write compare, 100/1 multistep
// - class 111/2 exec with testing; there is no 111/3 step
// - store starts in class 4 step 1, waits for buffer available
// - store source register reaches buffer data through the aligner path
// - store step 1: ea to buffer address, save next, set flag, ea+1
// - store step 1 issues a write and moves to class 3 step 1
// - store second slot without write hit advances pipe like no-op
// - write hit: buffer data replaces saved next, class 3 step 2
// - compare starts in class 4 step 1; ea, save next, set flag
// - compare step 1 reads operand and moves to class 7 step 2
// - compare slot tests register against memory word, equal or not
// - skip: pc to buffer address, pc+1, drop saved, read, class 3/2
// - no skip: advance pipe using the saved next instruction
// - indirect cycle when instruction ends and next has indirect bit
// - no general indirect cycle for conditional branch or undefined ops
// - indirect entry sets active flag, class 2 step 1
// - cell in memory: ea to buffer address, buffer data saved
// - state held as three class bits and three step bits
// - on termination the next instruction's initial state becomes present
// - cell in memory also sets flag, reads the cell, goes to class 2/2
module vpss_sequencer
   import vpss_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [`VPSS_NUM_VP-1:0] i_buf_avail,
   input wire vpss_mem_rsp_type i_mem_rsp,
   input wire logic [`VPSS_RA_W-1:0] i_reg_addr,
   input wire logic [`VPSS_WORD_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output vpss_mem_req_type o_mem_req,
   output logic [`VPSS_WORD_W-1:0] o_reg_rdata,
   output logic [`VPSS_VP_W-1:0] o_slot
);

   // expand a fetched word into the decoded instruction and its initial state
   function automatic vpss_instr_type expand(input logic [`VPSS_WORD_W-1:0] w);
      vpss_instr_type r;
      logic [3:0] opc;
      opc = w[`VPSS_OP_HI:`VPSS_OP_LO];
      r = '0;
      r.cmp_ne = (opc == `VPSS_OPC_CMP_NE);
      r.cell_in_reg = w[`VPSS_T_CELLREG];
      r.src_comm = w[`VPSS_R_COMM];
      r.src_idx = w[`VPSS_R_IDX_HI:`VPSS_R_IDX_LO];
      r.ea = w[`VPSS_EA_HI:`VPSS_EA_LO];
      // defaults: unknown ops behave as no-op and forbid indirection
      r.kind = VPSS_OP_OTHER;
      r.cls = `VPSS_CLS_ADV;
      r.step = `VPSS_STEP_2;
      r.ind_ok = 1'b0;
      if (opc == `VPSS_OPC_NOOP) begin
         r.kind = VPSS_OP_NOOP;
      end else if (opc == `VPSS_OPC_STORE) begin
         r.kind = VPSS_OP_STORE;
         r.cls = `VPSS_CLS_MULTI;
         r.step = `VPSS_STEP_1;
         r.ind_ok = 1'b1;
      end else if (opc == `VPSS_OPC_CMP_EQ || opc == `VPSS_OPC_CMP_NE) begin
         r.kind = VPSS_OP_CMP;
         r.cls = `VPSS_CLS_MULTI;
         r.step = `VPSS_STEP_1;
         r.ind_ok = 1'b1;
      end else if (opc == `VPSS_OPC_BR_COND) begin
         r.kind = VPSS_OP_BRANCH;
      end
      return r;
   endfunction : expand

   // register port space decode, shared by the write and read paths
   function automatic logic reg_in_space(input logic [`VPSS_RA_W-1:0] a,
         input logic [`VPSS_RA_W-`VPSS_RA_TAG_LO-1:0] tag);
      return a[`VPSS_RA_W-1:`VPSS_RA_TAG_LO] == tag;
   endfunction : reg_in_space

   // per-processor state, one entry per virtual processor, plus the shared communication registers
   vpss_instr_type instr_reg_q [`VPSS_NUM_VP];
   logic [`VPSS_ADDR_W-1:0] pc_q [`VPSS_NUM_VP];
   logic [`VPSS_ADDR_W-1:0] buffer_address_reg_q [`VPSS_NUM_VP];
   logic [`VPSS_WORD_W-1:0] buffer_data_reg_q [`VPSS_NUM_VP];
   logic [`VPSS_WORD_W-1:0] saved_next_instr_reg_q [`VPSS_NUM_VP];
   logic [`VPSS_WORD_W-1:0] vp_register_q [`VPSS_NUM_VP][`VPSS_NUM_REG];
   logic [`VPSS_WORD_W-1:0] comm_register_q [`VPSS_NUM_REG];

   logic [`VPSS_VP_W-1:0] slot_q;

   // slot-local view of the active processor
   vpss_instr_type slot_instr_copy;
   logic [`VPSS_ADDR_W-1:0] cur_pc;
   logic [`VPSS_WORD_W-1:0] cur_bdata;
   logic [`VPSS_WORD_W-1:0] cur_saved;
   logic [`VPSS_WORD_W-1:0] main_data_bus;
   logic [`VPSS_WORD_W-1:0] arith_output_bus;
   logic [`VPSS_WORD_W-1:0] indirect_cell_bus;
   logic buffer_available;
   logic write_hits_next_instr;
   logic skip_taken;
   logic instr_terminated;
   logic next_is_indirect;
   logic indirect_permitted;
   logic [`VPSS_WORD_W-1:0] next_word;
   vpss_instr_type next_exp;

   // next-slot values for the active processor
   vpss_instr_type instr_d;
   logic [`VPSS_ADDR_W-1:0] pc_d;
   logic [`VPSS_ADDR_W-1:0] baddr_d;
   logic [`VPSS_WORD_W-1:0] bdata_d;
   logic [`VPSS_WORD_W-1:0] saved_d;
   logic bdata_we;
   vpss_mem_req_type req_d;

   // round-robin time slots, one processor per cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         slot_q <= '0;
      end else begin
         slot_q <= slot_q + 3'h1;
      end
   end

   assign o_slot = slot_q;

   // slot copy of the instruction, fixed for the whole slot
   assign slot_instr_copy = instr_reg_q[slot_q];
   assign cur_pc = pc_q[slot_q];
   assign cur_bdata = buffer_data_reg_q[slot_q];
   assign cur_saved = saved_next_instr_reg_q[slot_q];
   assign buffer_available = i_buf_avail[slot_q];

   // source register over the processor or communication register path
   assign main_data_bus = slot_instr_copy.src_comm ?
      comm_register_q[slot_instr_copy.src_idx] :
      vp_register_q[slot_q][slot_instr_copy.src_idx];
   // aligner passes whole words, so the output bus equals its input
   assign arith_output_bus = main_data_bus;
   // register-held indirect cell; the address field names the register
   assign indirect_cell_bus = slot_instr_copy.src_comm ?
      comm_register_q[slot_instr_copy.ea[`VPSS_REG_IDX_W-1:0]] :
      vp_register_q[slot_q][slot_instr_copy.ea[`VPSS_REG_IDX_W-1:0]];

   // instruction ea already holds the store address plus one
   assign write_hits_next_instr = (slot_instr_copy.ea == cur_pc);
   // compare against the fetched word; sense chosen by the op-code
   assign skip_taken = (main_data_bus == cur_bdata) ^ slot_instr_copy.cmp_ne;

   // word that becomes the new instruction on a pipe advance
   assign next_word = slot_instr_copy.next_in_saved_flag ? cur_saved : cur_bdata;
   assign next_is_indirect = next_word[`VPSS_T_IND];
   // expanded once, shared by the indirect gate and the pipe advance
   assign next_exp = expand(next_word);
   assign indirect_permitted = next_exp.ind_ok;

   // next-state logic for the processor owning this slot
   always_comb begin
      instr_d = slot_instr_copy;
      pc_d = cur_pc;
      baddr_d = buffer_address_reg_q[slot_q];
      bdata_d = cur_bdata;
      saved_d = cur_saved;
      bdata_we = 1'b0;
      req_d = '0;
      instr_terminated = 1'b0;
      // while the buffer is busy nothing moves and no request leaves
      if (buffer_available) begin
         case (slot_instr_copy.cls)
            `VPSS_CLS_MULTI: begin
               if (slot_instr_copy.kind == VPSS_OP_STORE) begin
                  bdata_d = arith_output_bus;
                  bdata_we = 1'b1;
                  baddr_d = slot_instr_copy.ea;
                  saved_d = cur_bdata;
                  instr_d.next_in_saved_flag = 1'b1;
                  instr_d.ea = slot_instr_copy.ea + 16'h0001;
                  req_d.valid = 1'b1;
                  req_d.write = 1'b1;
                  req_d.data = arith_output_bus;
                  instr_d.cls = `VPSS_CLS_ADV;
                  instr_d.step = `VPSS_STEP_1;
               end else begin
                  baddr_d = slot_instr_copy.ea;
                  saved_d = cur_bdata;
                  instr_d.next_in_saved_flag = 1'b1;
                  req_d.valid = 1'b1;
                  instr_d.cls = `VPSS_CLS_EXEC;
                  instr_d.step = `VPSS_STEP_2;
               end
            end
            `VPSS_CLS_EXEC: begin
               // class 111 step 2: execution with skip testing
               if (skip_taken) begin
                  baddr_d = cur_pc;
                  pc_d = cur_pc + 16'h0001;
                  instr_d.next_in_saved_flag = 1'b0;
                  req_d.valid = 1'b1;
                  instr_d.cls = `VPSS_CLS_ADV;
                  instr_d.step = `VPSS_STEP_2;
               end else begin
                  instr_terminated = 1'b1;
               end
            end
            `VPSS_CLS_ADV: begin
               if (slot_instr_copy.step == `VPSS_STEP_1 && write_hits_next_instr) begin
                  saved_d = cur_bdata;
                  instr_d.cls = `VPSS_CLS_ADV;
                  instr_d.step = `VPSS_STEP_2;
               end else begin
                  instr_terminated = 1'b1;
               end
            end
            `VPSS_CLS_IND: begin
               if (slot_instr_copy.step == `VPSS_STEP_1) begin
                  if (!slot_instr_copy.cell_in_reg) begin
                     baddr_d = slot_instr_copy.ea;
                     req_d.valid = 1'b1;
                  end else begin
                     bdata_d = indirect_cell_bus;
                     bdata_we = 1'b1;
                  end
                  saved_d = cur_bdata;
                  instr_d.next_in_saved_flag = 1'b1;
                  instr_d.cls = `VPSS_CLS_IND;
                  instr_d.step = `VPSS_STEP_2;
               end else begin
                  // cell in buffer data: take its address, resume the instruction
                  instr_d = expand(cur_bdata);
                  instr_d.kind = slot_instr_copy.kind;
                  instr_d.cmp_ne = slot_instr_copy.cmp_ne;
                  instr_d.src_comm = slot_instr_copy.src_comm;
                  instr_d.src_idx = slot_instr_copy.src_idx;
                  instr_d.ea = cur_bdata[`VPSS_EA_HI:`VPSS_EA_LO];
                  instr_d.cls = `VPSS_CLS_MULTI;
                  instr_d.step = `VPSS_STEP_1;
                  instr_d.next_in_saved_flag = slot_instr_copy.next_in_saved_flag;
                  instr_d.dc = 1'b0;
               end
            end
            default: begin
               instr_terminated = 1'b1;
            end
         endcase
      end
      // pipe advance: the next instruction's initial state becomes present
      if (instr_terminated) begin
         baddr_d = cur_pc;
         pc_d = cur_pc + 16'h0001;
         instr_d = next_exp;
         instr_d.next_in_saved_flag = 1'b0;
         instr_d.interrupt_cycle_flag = 1'b0;
         req_d.valid = 1'b1;
         req_d.write = 1'b0;
         if (next_is_indirect && indirect_permitted) begin
            instr_d.dc = 1'b1;
            instr_d.cls = `VPSS_CLS_IND;
            instr_d.step = `VPSS_STEP_1;
         end
      end
      req_d.vp = slot_q;
      req_d.addr = baddr_d;
   end

   // request register toward the word buffer controller
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mem_req <= '0;
      end else begin
         o_mem_req <= req_d;
      end
   end

   // per-processor sequencing state, written only in the owner's slot
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int v = 0; v < `VPSS_NUM_VP; v++) begin
            instr_reg_q[v] <= '{kind: VPSS_OP_NOOP, cls: `VPSS_CLS_ADV,
                                step: `VPSS_STEP_2, default: '0};
            buffer_address_reg_q[v] <= '0;
            saved_next_instr_reg_q[v] <= '0;
         end
      end else begin
         instr_reg_q[slot_q] <= instr_d;
         buffer_address_reg_q[slot_q] <= baddr_d;
         saved_next_instr_reg_q[slot_q] <= saved_d;
      end
   end

   // program counters: slot update, software load wins even in the owner's slot
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int v = 0; v < `VPSS_NUM_VP; v++) begin
            pc_q[v] <= '0;
         end
      end else begin
         pc_q[slot_q] <= pc_d;
         if (i_reg_wr && reg_in_space(i_reg_addr, `VPSS_RA_PC_TAG)) begin
            pc_q[i_reg_addr[2:0]] <= i_reg_wdata[`VPSS_ADDR_W-1:0];
         end
      end
   end

   // buffer data: slot writes beat a returning word for the same processor
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int v = 0; v < `VPSS_NUM_VP; v++) begin
            buffer_data_reg_q[v] <= '0;
         end
      end else begin
         if (i_mem_rsp.valid) begin
            buffer_data_reg_q[i_mem_rsp.vp] <= i_mem_rsp.data;
         end
         if (bdata_we) begin
            buffer_data_reg_q[slot_q] <= bdata_d;
         end
      end
   end

   // register file loads from the software port
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int v = 0; v < `VPSS_NUM_VP; v++) begin
            for (int r = 0; r < `VPSS_NUM_REG; r++) begin
               vp_register_q[v][r] <= '0;
            end
         end
         for (int r = 0; r < `VPSS_NUM_REG; r++) begin
            comm_register_q[r] <= '0;
         end
      end else if (i_reg_wr) begin
         if (!i_reg_addr[`VPSS_RA_SPACE_BIT]) begin
            vp_register_q[i_reg_addr[`VPSS_RA_VP_HI:`VPSS_RA_VP_LO]]
               [i_reg_addr[`VPSS_REG_IDX_W-1:0]] <= i_reg_wdata;
         end else if (!i_reg_addr[`VPSS_RA_CTRL_BIT]) begin
            comm_register_q[i_reg_addr[`VPSS_REG_IDX_W-1:0]] <= i_reg_wdata;
         end
      end
   end

   // read port: data stands in the cycle after the strobe only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata <= '0;
      end else begin
         o_reg_rdata <= '0;
         if (i_reg_rd) begin
            if (!i_reg_addr[`VPSS_RA_SPACE_BIT]) begin
               o_reg_rdata <= vp_register_q[i_reg_addr[`VPSS_RA_VP_HI:`VPSS_RA_VP_LO]]
                  [i_reg_addr[`VPSS_REG_IDX_W-1:0]];
            end else if (!i_reg_addr[`VPSS_RA_CTRL_BIT]) begin
               o_reg_rdata <= comm_register_q[i_reg_addr[`VPSS_REG_IDX_W-1:0]];
            end else if (reg_in_space(i_reg_addr, `VPSS_RA_PC_TAG)) begin
               o_reg_rdata <= {16'h0000, pc_q[i_reg_addr[2:0]]};
            end else if (reg_in_space(i_reg_addr, `VPSS_RA_STAT_TAG)) begin
               // status: dc, nil, class, step of the addressed processor
               o_reg_rdata <= {24'h000000, instr_reg_q[i_reg_addr[2:0]].dc,
                  instr_reg_q[i_reg_addr[2:0]].next_in_saved_flag, instr_reg_q[i_reg_addr[2:0]].cls,
                  instr_reg_q[i_reg_addr[2:0]].step};
            end
         end
      end
   end

endmodule : vpss_sequencer

// *** design/vpss_defs.svh ***
`ifndef VPSS_DEFS_SVH
`define VPSS_DEFS_SVH

// processor and word geometry
`define VPSS_NUM_VP 8
`define VPSS_VP_W 3
`define VPSS_WORD_W 32
`define VPSS_ADDR_W 16
`define VPSS_REG_IDX_W 4
`define VPSS_NUM_REG 16

// instruction word fields
`define VPSS_OP_HI 31
`define VPSS_OP_LO 28
`define VPSS_T_IND 27
`define VPSS_T_CELLREG 26
`define VPSS_R_COMM 23
`define VPSS_R_IDX_HI 22
`define VPSS_R_IDX_LO 19
`define VPSS_EA_HI 15
`define VPSS_EA_LO 0

// op-code values
`define VPSS_OPC_NOOP 4'h0
`define VPSS_OPC_STORE 4'h1
`define VPSS_OPC_CMP_EQ 4'h2
`define VPSS_OPC_CMP_NE 4'h3
`define VPSS_OPC_BR_COND 4'h4

// state classes and steps
`define VPSS_CLS_IND 3'h2
`define VPSS_CLS_ADV 3'h3
`define VPSS_CLS_MULTI 3'h4
`define VPSS_CLS_EXEC 3'h7
`define VPSS_STEP_1 3'h1
`define VPSS_STEP_2 3'h2

// register port map
`define VPSS_RA_W 8
`define VPSS_RA_SPACE_BIT 7
`define VPSS_RA_CTRL_BIT 6
`define VPSS_RA_PC_BASE 8'hC0
`define VPSS_RA_STAT_BASE 8'hC8
`define VPSS_RA_VP_HI 6
`define VPSS_RA_VP_LO 4
`define VPSS_RA_TAG_LO 3
`define VPSS_RA_PC_TAG 5'h18
`define VPSS_RA_STAT_TAG 5'h19

`endif

// *** design/vpss_pkg.sv ***
package vpss_pkg;
`include "vpss_defs.svh"

   typedef enum logic [3:0] {
      VPSS_OP_NOOP,
      VPSS_OP_STORE,
      VPSS_OP_CMP,
      VPSS_OP_BRANCH,
      VPSS_OP_OTHER
   } vpss_op_type;

   // decoded instruction held per virtual processor
   typedef struct packed {
      vpss_op_type kind;
      logic cmp_ne;
      logic ind_ok;
      logic cell_in_reg;
      logic src_comm;
      logic [`VPSS_REG_IDX_W-1:0] src_idx;
      logic [`VPSS_ADDR_W-1:0] ea;
      logic [2:0] cls;
      logic [2:0] step;
      logic next_in_saved_flag;
      logic dc;
      logic interrupt_cycle_flag;
   } vpss_instr_type;

   // request to the word buffer controller
   typedef struct packed {
      logic valid;
      logic write;
      logic [`VPSS_VP_W-1:0] vp;
      logic [`VPSS_ADDR_W-1:0] addr;
      logic [`VPSS_WORD_W-1:0] data;
   } vpss_mem_req_type;

   // word returned by the word buffer controller
   typedef struct packed {
      logic valid;
      logic [`VPSS_VP_W-1:0] vp;
      logic [`VPSS_WORD_W-1:0] data;
   } vpss_mem_rsp_type;

endpackage : vpss_pkg

// *** testbench/vpss_word_buffer_model.sv ***
`timescale 1ns/1ps
`include "vpss_defs.svh"

module vpss_word_buffer_model
   import vpss_pkg::*;
#(
   parameter int SLOW_DLY = 5
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_slow,
   input wire vpss_mem_req_type i_req,
   output vpss_mem_rsp_type o_rsp
);
   logic [`VPSS_WORD_W-1:0] mem_q [0:(1<<`VPSS_ADDR_W)-1];
   vpss_mem_rsp_type pipe_q [0:7];
   logic [`VPSS_WORD_W-1:0] last_q;

   // writes land at once; reads ride a delay line, slow mode still beats the next slot
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < 8; i++) pipe_q[i] <= '0;
         last_q <= '0;
      end else begin
         for (int i = 0; i < 7; i++) pipe_q[i] <= pipe_q[i+1];
         pipe_q[7] <= '0;
         if (pipe_q[0].valid) last_q <= pipe_q[0].data;
         if (i_req.valid && i_req.write) begin
            mem_q[i_req.addr] <= i_req.data;
         end else if (i_req.valid) begin
            pipe_q[i_slow ? SLOW_DLY : 0] <= '{1'b1, i_req.vp, mem_q[i_req.addr]};
         end
      end
   end

   // idle data lines toggle so a stale word is never mistaken for a fresh one
   always_comb begin
      o_rsp = pipe_q[0];
      if (!pipe_q[0].valid) o_rsp.data = ~last_q;
   end
endmodule : vpss_word_buffer_model

// *** testbench/vpss_sequencer_props.sv ***
`timescale 1ns/1ps
`include "vpss_defs.svh"

module vpss_sequencer_props
   import vpss_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [`VPSS_NUM_VP-1:0] i_buf_avail,
   input wire vpss_mem_rsp_type i_mem_rsp,
   input wire logic [`VPSS_RA_W-1:0] i_reg_addr,
   input wire logic [`VPSS_WORD_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire vpss_mem_req_type o_mem_req,
   input wire logic [`VPSS_WORD_W-1:0] o_reg_rdata,
   input wire logic [`VPSS_VP_W-1:0] o_slot
);
   logic avail_q;
   logic [`VPSS_VP_W-1:0] slot_q;

   // slot owner one cycle back, since a request leaves the cycle after its slot
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         avail_q <= 1'b0;
         slot_q <= '0;
      end else begin
         avail_q <= i_buf_avail[o_slot];
         slot_q <= o_slot;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   // request steps
   sequence s_req_out; o_mem_req.valid; endsequence
   sequence s_write_out; o_mem_req.valid && o_mem_req.write; endsequence
   sequence s_slot_busy; !i_buf_avail[o_slot]; endsequence

   property p_slot_step; $past(i_rst_n) |-> o_slot == $past(o_slot) + 3'h1; endproperty
   property p_req_owner; s_req_out |-> o_mem_req.vp == slot_q; endproperty
   property p_req_avail; s_req_out |-> avail_q; endproperty
   property p_busy_quiet; s_slot_busy |=> !o_mem_req.valid; endproperty
   property p_write_next; s_write_out |-> ##8 !(o_mem_req.valid && o_mem_req.write); endproperty
   property p_reset_start; $rose(i_rst_n) |-> o_slot == 3'h0 && !o_mem_req.valid; endproperty
   property p_rdata_idle; !i_reg_rd |=> o_reg_rdata == '0; endproperty
   property p_unmapped; i_reg_rd && i_reg_addr == 8'hFF |=> o_reg_rdata == '0; endproperty

   a_slot_step: assert property (p_slot_step)
      else $error("slot order broken");
   a_req_owner: assert property (p_req_owner)
      else $error("request from a processor outside its slot");
   a_req_avail: assert property (p_req_avail)
      else $error("request while buffer busy");
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("transfer started with buffer busy");
   a_write_next: assert property (p_write_next)
      else $error("write repeated in the slot after a store write");
   a_reset_start: assert property (p_reset_start)
      else $error("bad state after reset release");
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside its cycle");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped address read nonzero");
endmodule : vpss_sequencer_props

bind vpss_sequencer vpss_sequencer_props u_props (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_buf_avail(i_buf_avail), .i_mem_rsp(i_mem_rsp),
   .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd), .o_mem_req(o_mem_req), .o_reg_rdata(o_reg_rdata), .o_slot(o_slot)
);

// *** testbench/vp_instruction_step_sequencer_tb.sv ***
`timescale 1ns/1ps
`include "vpss_defs.svh"

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module vp_instruction_step_sequencer_tb
   import vpss_pkg::*;
();
   typedef struct packed {
      logic [2:0] vp;
      logic av;
      logic vld;
      logic wr;
      logic [15:0] addr;
      logic [31:0] data;
   } vpss_row_type;

   logic i_clk;
   logic i_rst_n;
   logic i_slow;
   logic [`VPSS_NUM_VP-1:0] i_buf_avail;
   vpss_mem_rsp_type mem_rsp;
   logic [`VPSS_RA_W-1:0] reg_addr;
   logic [`VPSS_WORD_W-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   vpss_mem_req_type mem_req;
   logic [`VPSS_WORD_W-1:0] reg_rdata;
   logic [`VPSS_VP_W-1:0] slot;
   logic [`VPSS_WORD_W-1:0] rd_val;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   // per slot: processor, buffer free, expected request
   vpss_row_type rows [28] = '{
      '{3'h0, 1'h1, 1'h1, 1'h0, 16'h0000, 32'h0}, '{3'h0, 1'h0, 1'h0, 1'h0, 16'h0, 32'h0},
      '{3'h0, 1'h1, 1'h1, 1'h0, 16'h0001, 32'h0}, '{3'h0, 1'h1, 1'h1, 1'h1, 16'h0040, 32'hA5A50F0F},
      '{3'h0, 1'h1, 1'h1, 1'h0, 16'h0002, 32'h0}, '{3'h0, 1'h1, 1'h1, 1'h0, 16'h0040, 32'h0},
      '{3'h0, 1'h0, 1'h0, 1'h0, 16'h0, 32'h0}, '{3'h0, 1'h1, 1'h1, 1'h0, 16'h0003, 32'h0},
      '{3'h0, 1'h1, 1'h1, 1'h0, 16'h0004, 32'h0}, '{3'h0, 1'h1, 1'h1, 1'h0, 16'h0080, 32'h0},
      '{3'h0, 1'h1, 1'h0, 1'h0, 16'h0, 32'h0}, '{3'h0, 1'h1, 1'h1, 1'h1, 16'h0050, 32'h12345678},
      '{3'h1, 1'h1, 1'h1, 1'h0, 16'h0100, 32'h0}, '{3'h1, 1'h1, 1'h1, 1'h0, 16'h0101, 32'h0},
      '{3'h1, 1'h1, 1'h1, 1'h1, 16'h0101, 32'h10000070}, '{3'h1, 1'h1, 1'h0, 1'h0, 16'h0, 32'h0},
      '{3'h1, 1'h1, 1'h1, 1'h0, 16'h0102, 32'h0}, '{3'h1, 1'h1, 1'h1, 1'h1, 16'h0070, 32'hC3C33C3C},
      // processor 2: compare without skip, shared register source, branch, register cell
      '{3'h2, 1'h1, 1'h1, 1'h0, 16'h0200, 32'h0}, '{3'h2, 1'h1, 1'h1, 1'h0, 16'h0201, 32'h0},
      '{3'h2, 1'h1, 1'h1, 1'h0, 16'h0210, 32'h0}, '{3'h2, 1'h1, 1'h1, 1'h0, 16'h0202, 32'h0},
      '{3'h2, 1'h1, 1'h1, 1'h1, 16'h0220, 32'h0F0F7777}, '{3'h2, 1'h1, 1'h1, 1'h0, 16'h0203, 32'h0},
      '{3'h2, 1'h1, 1'h1, 1'h0, 16'h0204, 32'h0}, '{3'h2, 1'h1, 1'h0, 1'h0, 16'h0, 32'h0},
      '{3'h2, 1'h1, 1'h0, 1'h0, 16'h0, 32'h0}, '{3'h2, 1'h1, 1'h1, 1'h1, 16'h0230, 32'h5A5A1234}
   };

   vpss_sequencer dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_buf_avail(i_buf_avail), .i_mem_rsp(mem_rsp),
      .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .o_mem_req(mem_req), .o_reg_rdata(reg_rdata), .o_slot(slot)
   );

   vpss_word_buffer_model u_mem (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(i_slow), .i_req(mem_req), .o_rsp(mem_rsp)
   );

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run

   task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge i_clk);
      reg_wr <= 1'h0;
   endtask : write_reg

   // read data is only valid in the cycle after the strobe
   task automatic check_reg(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge i_clk);
      reg_rd <= 1'h0;
      @(negedge i_clk);
      rd_val = reg_rdata;
      `CHK(rd_val, e)
   endtask : check_reg

   task automatic wait_slot(input logic [2:0] s);
      do @(negedge i_clk); while (slot !== s);
   endtask : wait_slot

   initial begin
      i_clk = 1'h0;
      forever #50 i_clk = ~i_clk;
   end

   // hang guard, well above the expected run length
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         complete_run();
      end
   end

   initial begin
      i_rst_n = 1'h0;
      i_slow = 1'h0;
      i_buf_avail = 8'h00;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      for (int a = 0; a < 65536; a++) u_mem.mem_q[a] = 32'h0;
      u_mem.mem_q[0] = 32'h10280040;
      u_mem.mem_q[1] = 32'h20280040;
      u_mem.mem_q[2] = 32'h10000060;
      u_mem.mem_q[3] = 32'h18000080;
      u_mem.mem_q[16'h80] = 32'h00000050;
      u_mem.mem_q[16'h100] = 32'h10100101;
      u_mem.mem_q[16'h200] = 32'h30080210;
      u_mem.mem_q[16'h201] = 32'h10980220;
      u_mem.mem_q[16'h202] = 32'h48000000;
      u_mem.mem_q[16'h203] = 32'h1C080002;
      u_mem.mem_q[16'h210] = 32'h5A5A1234;
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'h1;
      check_reg(8'hC8, 32'h1A);
      write_reg(8'h05, 32'hA5A50F0F);
      write_reg(8'h00, 32'h12345678);
      write_reg(8'h12, 32'h10000070);
      write_reg(8'h10, 32'hC3C33C3C);
      write_reg(8'hC1, 32'h100);
      write_reg(8'hC2, 32'h200);
      write_reg(8'h21, 32'h5A5A1234);
      write_reg(8'h22, 32'h230);
      write_reg(8'h83, 32'h0F0F7777);
      check_reg(8'hC1, 32'h100);
      for (int i = 0; i < 28; i++) begin
         if (i == 12) i_slow <= 1'h1;
         wait_slot(rows[i].vp - 3'h1);
         @(posedge i_clk);
         i_buf_avail <= {7'h00, rows[i].av} << rows[i].vp;
         @(posedge i_clk);
         i_buf_avail <= 8'h00;
         @(negedge i_clk);
         `CHK(mem_req.valid, rows[i].vld)
         if (rows[i].vld) begin
            `CHK(mem_req.vp, rows[i].vp)
            `CHK(mem_req.write, rows[i].wr)
            `CHK(mem_req.addr, rows[i].addr)
         end
         if (rows[i].wr) begin
            `CHK(mem_req.data, rows[i].data)
         end
         $display("row %0d done", i);
      end
      check_reg(8'hC8, 32'h59);
      check_reg(8'hC0, 32'h5);
      check_reg(8'hC2, 32'h205);
      write_reg(8'hC8, 32'hFF);
      check_reg(8'hC8, 32'h59);
      check_reg(8'hFF, 32'h0);
      $display("status test done");
      // reset lands after five slots of fetching, with every buffer free
      @(posedge i_clk);
      i_buf_avail <= 8'hFF;
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'h0;
      repeat (10) @(posedge i_clk);
      i_buf_avail <= 8'h00;
      i_rst_n <= 1'h1;
      check_reg(8'hC8, 32'h1A);
      check_reg(8'hC0, 32'h0);
      $display("reset test done");
      complete_run();
   end
endmodule : vp_instruction_step_sequencer_tb
